// *** psw_pkg.sv ***
// Constants, field layout and command codes of the processor status word.
// Assumes a single core clock; shared by the status bank and its slot decoder.
package psw_pkg;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PSW_W          = 64;
  localparam int POS_EXT_INTR   = 14;
  localparam int POS_CPL_LO     = 32;
  localparam int POS_CPL_HI     = 33;
  localparam int POS_LEGACY     = 34;
  localparam int POS_MC_MASK    = 35;
  localparam int POS_IT_EN      = 36;
  localparam int POS_SLOT_LO    = 41;
  localparam int POS_SLOT_HI    = 42;
  localparam int POS_DEFER      = 43;
  localparam int POS_BANK       = 44;
  localparam int POS_IA_DIS     = 45;

  // ----------------------------------------------------------------
  // Masks and reset value
  // ----------------------------------------------------------------
  localparam logic [63:0] PSW_RESET    = 64'h0000_0000_0000_0000;
  localparam logic [63:0] MASK_USER    = 64'h0000_0000_0000_003F;
  localparam logic [63:0] MASK_SYSTEM  = 64'h0000_0000_00FF_FFFF;
  localparam logic [63:0] MASK_LOWER   = 64'h0000_0000_FFFF_FFFF;
  localparam logic [63:0] MASK_READ    = 64'h0000_0018_FFFF_FFFF;
  localparam logic [63:0] MASK_RSVD    = 64'hFFFF_C000_0000_0000;
  localparam logic [63:0] MASK_ONESHOT = 64'h0000_28E0_0000_0000;
  localparam logic [1:0]  SLOT_RSVD    = 2'h3;
  localparam logic [1:0]  CPL_MOST     = 2'h0;

  // ----------------------------------------------------------------
  // Commands, interruption kinds, first-instruction classes
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PSW_OP_NONE      = 4'h0,
    PSW_OP_SUM       = 4'h1,
    PSW_OP_RUM       = 4'h2,
    PSW_OP_MOV_UM    = 4'h3,
    PSW_OP_SSM       = 4'h4,
    PSW_OP_RSM       = 4'h5,
    PSW_OP_MOV_L     = 4'h6,
    PSW_OP_MOV_FROM  = 4'h7,
    PSW_OP_RFI       = 4'h8,
    PSW_OP_BSW       = 4'h9,
    PSW_OP_RETIRE    = 4'hA,
    PSW_OP_TO_LEGACY = 4'hB,
    PSW_OP_SRLZ      = 4'hC,
    PSW_OP_SAVED_WR  = 4'hD,
    PSW_OP_SAVED_RD  = 4'hE
  } psw_op_t;

  typedef enum logic [1:0] {
    PSW_INT_NORMAL   = 2'h0,
    PSW_INT_MCHECK   = 2'h1,
    PSW_INT_INIT     = 2'h2,
    PSW_INT_FIRMWARE = 2'h3
  } psw_int_t;

  typedef enum logic [1:0] {
    PSW_CL_OTHER     = 2'h0,
    PSW_CL_SPEC_LD   = 2'h1,
    PSW_CL_SPEC_ADV  = 2'h2,
    PSW_CL_PREFETCH  = 2'h3
  } psw_class_t;

endpackage

// *** psw_slot_ctl.sv ***
// Restart-slot decoder: turns the slot field into a per-slot execute mask.
// Assumes load is a one-cycle pulse issued on return from interruption.
`timescale 1ns/10ps
module psw_slot_ctl
  import psw_pkg::*;
#(
  parameter int SLOTS = 3
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             load,
  input  wire logic [1:0]       slot,
  input  wire logic             legacy,
  output logic      [SLOTS-1:0] slot_enable
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Slots at or after the restart point run, earlier ones are skipped
  logic [SLOTS-1:0] next_enable;
  genvar g;
  generate
    for (g = 0; g < SLOTS; g++) begin : gen_slot
      assign next_enable[g] = legacy ? 1'b1 :
                              (slot != SLOT_RSVD) && (g >= int'(slot));
    end
  endgenerate

  // Mask held until the next restart
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slot_enable <= '1;
    end else if (load) begin
      slot_enable <= next_enable;
    end
  end

endmodule

// *** psw_bank_ctl.sv ***
// Register bank switch sequencer for the upper general registers.
// Assumes loads_outstanding stays high while any old-bank load is in flight.
`timescale 1ns/10ps
module psw_bank_ctl (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic switch_req,
  input  wire logic new_bank,
  input  wire logic loads_outstanding,
  output logic      bank,
  output logic      stall
);

  // ----------------------------------------------------------------
  // Pending switch
  // ----------------------------------------------------------------
  logic target;
  wire  pend_now  = stall | switch_req;
  wire  want_bank = switch_req ? new_bank : target;
  wire  apply     = pend_now && !loads_outstanding;

  // New bank only after the old one has drained; later accesses stall
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bank   <= 1'b0;
      stall  <= 1'b0;
      target <= 1'b0;
    end else begin
      target <= want_bank;
      stall  <= pend_now && !apply;
      if (apply) begin
        bank <= want_bank;
      end
    end
  end

endmodule

// *** psw_status_bank.sv ***
// Processor status word: upper fields, partial updates, save and restore.
// Assumes one committed command per cycle from the core's retire stage and
// that interruption delivery wins over any command in the same cycle.
//
// How it works
// - Two-bit restart slot picks slot zero, one or two; code three reserved.
// - Selected slot and later ones run; earlier slots treated as not executed.
// - Interruption stores next slot in saved copy; software may also load it.
// - Legacy restarts ignore the slot field; its value afterwards is undefined.
// - Deferral bit with speculative load: mark deferred, no access, keep increment.
// - Deferred speculative advanced load purges its advanced load table entry.
// - Deferred line prefetch skips promotion; other first instructions unaffected.
// - Bank bit selects bank one or zero for registers sixteen to thirty-one.
// - Bank bit written by return and bank switch; cleared on interruption.
// - Old-bank accesses and loads finish before new-bank accesses start.
// - Access-bit disable suppresses first restarted native instruction fault only.
// - One-shot disables clear after each native instruction; return may set them.
// - One-shots ignored for legacy; cleared when entering legacy completes.
// - Return-only fields change only by return, which fully serializes.
// - User mask ops work at any level and take effect for later groups.
// - System mask set and clear are privileged; software must serialize.
// - Lower half write is privileged; visible only after serialization.
// - Status read returns only bits 36:35 and 31:0.
// - Return loads the whole word from the saved copy and serializes.
// - Masking by clear acts next instruction; unmasking waits for serialization.
// - Machine check mask set after machine check or init, else unchanged.
// - Translation bit kept on interruption, cleared after firmware interruption.
`timescale 1ns/10ps
module psw_status_bank
  import psw_pkg::*;
#(
  parameter int SLOTS = 3
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             op_valid,
  input  wire psw_op_t          op_code,
  input  wire logic [63:0]      op_data,
  input  wire logic             intr_take,
  input  wire psw_int_t         intr_kind,
  input  wire logic [1:0]       intr_next_slot,
  input  wire logic             first_valid,
  input  wire psw_class_t       first_class,
  input  wire logic             loads_outstanding,
  output logic      [63:0]      status_word,
  output logic      [63:0]      status_visible,
  output logic      [63:0]      saved_status_copy,
  output logic      [63:0]      read_data,
  output logic                  read_valid,
  output logic                  priv_fault,
  output logic                  gr_bank_select,
  output logic                  bank_stall,
  output logic      [SLOTS-1:0] slot_enable,
  output logic                  force_defer_mark,
  output logic                  mem_access_suppress,
  output logic                  advanced_load_table_purge,
  output logic                  promotion_skip,
  output logic                  accessbit_fault_suppress
);

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Privilege is judged on the word as it stands before the command
  wire       cmd        = op_valid && !intr_take;
  wire       privileged = status_word[POS_CPL_HI:POS_CPL_LO] == CPL_MOST;
  wire       is_sum     = cmd && op_code == PSW_OP_SUM;
  wire       is_rum     = cmd && op_code == PSW_OP_RUM;
  wire       is_mov_um  = cmd && op_code == PSW_OP_MOV_UM;
  wire       is_user    = is_sum || is_rum || is_mov_um;
  wire       needs_priv = cmd && (op_code == PSW_OP_SSM || op_code == PSW_OP_RSM ||
                                  op_code == PSW_OP_MOV_L || op_code == PSW_OP_MOV_FROM ||
                                  op_code == PSW_OP_RFI || op_code == PSW_OP_BSW ||
                                  op_code == PSW_OP_SAVED_WR ||
                                  op_code == PSW_OP_SAVED_RD);
  wire       fault_now  = needs_priv && !privileged;
  wire       pcmd       = cmd && privileged;
  wire       is_ssm     = pcmd && op_code == PSW_OP_SSM;
  wire       is_rsm     = pcmd && op_code == PSW_OP_RSM;
  wire       is_mov_l   = pcmd && op_code == PSW_OP_MOV_L;
  wire       is_rd      = pcmd && op_code == PSW_OP_MOV_FROM;
  wire       is_rfi     = pcmd && op_code == PSW_OP_RFI;
  wire       is_bsw     = pcmd && op_code == PSW_OP_BSW;
  wire       is_sv_wr   = pcmd && op_code == PSW_OP_SAVED_WR;
  wire       is_sv_rd   = pcmd && op_code == PSW_OP_SAVED_RD;
  wire       is_srlz    = cmd && op_code == PSW_OP_SRLZ;
  wire       legacy_now = status_word[POS_LEGACY];
  wire       is_retire  = cmd && op_code == PSW_OP_RETIRE && !legacy_now;
  wire       is_to_leg  = cmd && op_code == PSW_OP_TO_LEGACY;

  // ----------------------------------------------------------------
  // Interruption image
  // ----------------------------------------------------------------
  // Word after delivery: privilege 0, native set, bank 0, one-shots off
  logic [63:0] intr_word;
  always_comb begin
    intr_word                              = status_word;
    intr_word[POS_CPL_HI:POS_CPL_LO]       = CPL_MOST;
    intr_word[POS_LEGACY]                  = 1'b0;
    intr_word[POS_BANK]                    = 1'b0;
    intr_word                              = intr_word & ~MASK_ONESHOT;
    if (intr_kind == PSW_INT_MCHECK || intr_kind == PSW_INT_INIT) begin
      intr_word[POS_MC_MASK] = 1'b1;
    end
    if (intr_kind == PSW_INT_FIRMWARE) begin
      intr_word[POS_IT_EN] = 1'b0;
    end
  end

  // Saved copy records the slot of the next instruction to run
  logic [63:0] intr_save;
  always_comb begin
    intr_save                          = status_word;
    intr_save[POS_SLOT_HI:POS_SLOT_LO] = intr_next_slot;
  end

  // ----------------------------------------------------------------
  // Restore image
  // ----------------------------------------------------------------
  // Return takes the whole saved word; a legacy target drops one-shots
  logic [63:0] rfi_word;
  always_comb begin
    rfi_word = saved_status_copy & ~MASK_RSVD;
    if (rfi_word[POS_LEGACY]) begin
      rfi_word = rfi_word & ~MASK_ONESHOT;
    end
  end

  // ----------------------------------------------------------------
  // Next status word
  // ----------------------------------------------------------------
  // Return-only fields are touched only by the intr and rfi branches
  logic [63:0] next_status;
  always_comb begin
    next_status = status_word;
    if (intr_take) begin
      next_status = intr_word;
    end else if (is_rfi) begin
      next_status = rfi_word;
    end else if (is_sum) begin
      next_status = status_word | (op_data & MASK_USER);
    end else if (is_rum) begin
      next_status = status_word & ~(op_data & MASK_USER);
    end else if (is_mov_um) begin
      next_status = (status_word & ~MASK_USER) | (op_data & MASK_USER);
    end else if (is_ssm) begin
      next_status = status_word | (op_data & MASK_SYSTEM);
    end else if (is_rsm) begin
      next_status = status_word & ~(op_data & MASK_SYSTEM);
    end else if (is_mov_l) begin
      next_status = (status_word & ~MASK_LOWER) | (op_data & MASK_LOWER);
    end else if (is_bsw) begin
      next_status[POS_BANK] = op_data[0];
    end else if (is_retire) begin
      next_status = status_word & ~MASK_ONESHOT;
    end else if (is_to_leg) begin
      next_status             = status_word & ~MASK_ONESHOT;
      next_status[POS_LEGACY] = 1'b1;
    end
    next_status = next_status & ~MASK_RSVD;
  end

  // ----------------------------------------------------------------
  // Word seen by dependent instructions
  // ----------------------------------------------------------------
  // Lags the architectural word until serialization; masking acts at once
  logic [63:0] next_visible;
  always_comb begin
    next_visible = status_visible;
    if (intr_take || is_rfi || is_srlz || is_bsw || is_to_leg) begin
      next_visible = next_status;
    end else if (is_user) begin
      next_visible = (status_visible & ~MASK_USER) | (next_status & MASK_USER);
    end else if (is_rsm) begin
      next_visible = status_visible & ~(op_data & MASK_SYSTEM);
    end else if (is_retire) begin
      next_visible = status_visible & ~MASK_ONESHOT;
    end
  end

  // ----------------------------------------------------------------
  // Saved copy and reads
  // ----------------------------------------------------------------
  wire [63:0] next_saved = intr_take ? intr_save :
                           is_sv_wr  ? (op_data & ~MASK_RSVD) : saved_status_copy;
  wire [63:0] read_sel   = is_sv_rd ? saved_status_copy :
                           (status_word & MASK_READ);
  wire        read_now   = is_rd || is_sv_rd;

  // Architectural state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_word       <= PSW_RESET;
      status_visible    <= PSW_RESET;
      saved_status_copy <= PSW_RESET;
    end else begin
      status_word       <= next_status;
      status_visible    <= next_visible;
      saved_status_copy <= next_saved;
    end
  end

  // Read return and privilege fault, one cycle after the command
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      read_data  <= '0;
      read_valid <= 1'b0;
      priv_fault <= 1'b0;
    end else begin
      read_valid <= read_now;
      priv_fault <= fault_now;
      if (read_now) begin
        read_data <= read_sel;
      end
    end
  end

  // ----------------------------------------------------------------
  // First restarted instruction
  // ----------------------------------------------------------------
  // One-shot bits are cleared on retire, so they only cover the first one
  wire first_native = first_valid && !legacy_now;
  wire defer_on     = first_native && status_word[POS_DEFER];
  wire cls_load     = first_class == PSW_CL_SPEC_LD || first_class == PSW_CL_SPEC_ADV;
  wire next_defer   = defer_on && cls_load;
  wire next_purge   = defer_on && first_class == PSW_CL_SPEC_ADV;
  wire next_skip    = defer_on && first_class == PSW_CL_PREFETCH;
  wire next_ia_sup  = first_native && status_word[POS_IA_DIS];

  // Post-increment is left to the core: only the access is suppressed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      force_defer_mark         <= 1'b0;
      mem_access_suppress      <= 1'b0;
      advanced_load_table_purge               <= 1'b0;
      promotion_skip           <= 1'b0;
      accessbit_fault_suppress <= 1'b0;
    end else begin
      force_defer_mark         <= next_defer;
      mem_access_suppress      <= next_defer || next_skip;
      advanced_load_table_purge               <= next_purge;
      promotion_skip           <= next_skip;
      accessbit_fault_suppress <= next_ia_sup;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Slot mask loads on return; legacy targets run whole
  psw_slot_ctl #(
    .SLOTS       (SLOTS)
  ) u_slot (
    .clk         (clk),
    .reset_n     (reset_n),
    .load        (is_rfi),
    .slot        (rfi_word[POS_SLOT_HI:POS_SLOT_LO]),
    .legacy      (rfi_word[POS_LEGACY]),
    .slot_enable (slot_enable)
  );

  // Physical bank follows the status bit once old-bank loads drain
  wire bank_req = intr_take || is_rfi || is_bsw;
  psw_bank_ctl u_bank (
    .clk               (clk),
    .reset_n           (reset_n),
    .switch_req        (bank_req),
    .new_bank          (next_status[POS_BANK]),
    .loads_outstanding (loads_outstanding),
    .bank              (gr_bank_select),
    .stall             (bank_stall)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_intr;
    intr_take;
  endsequence
  sequence s_bank_cleared;
    !status_word[POS_BANK] && status_word[POS_CPL_HI:POS_CPL_LO] == CPL_MOST;
  endsequence

  a_rsvd_zero: assert property (status_word[63:46] == '0 && status_visible[63:46] == '0)
    else $error("reserved status bits not zero");
  a_intr_bank_clear: assert property (s_intr |=> s_bank_cleared)
    else $error("bank bit not cleared on interruption");
  a_intr_slot_saved: assert property (intr_take |=>
      saved_status_copy[POS_SLOT_HI:POS_SLOT_LO] == $past(intr_next_slot))
    else $error("restart slot not recorded");
  a_rfi_restore: assert property (is_rfi && !saved_status_copy[POS_LEGACY] |=>
      status_word == ($past(saved_status_copy) & ~MASK_RSVD))
    else $error("return did not restore status");
  a_read_mask: assert property (is_rd |=> read_valid && read_data == ($past(status_word) & MASK_READ))
    else $error("status read exposes hidden bits");
  a_retire_clear: assert property (is_retire |=> (status_word & MASK_ONESHOT) == '0)
    else $error("one-shot bits survive retire");
  a_mc_set: assert property (intr_take && intr_kind != PSW_INT_NORMAL
      && intr_kind != PSW_INT_FIRMWARE |=> status_word[POS_MC_MASK])
    else $error("machine check mask not set");
  a_fw_it_clear: assert property (intr_take && intr_kind == PSW_INT_FIRMWARE |=>
      !status_word[POS_IT_EN])
    else $error("translation bit kept after firmware interruption");
  a_mask_now: assert property (is_rsm && op_data[POS_EXT_INTR] |=>
      !status_visible[POS_EXT_INTR])
    else $error("interrupt masking not immediate");
  a_ssm_lag: assert property (is_ssm && !status_visible[POS_EXT_INTR] && op_data[POS_EXT_INTR]
      ##1 !(intr_take || is_srlz || is_rfi || is_bsw || is_to_leg) |=>
      !status_visible[POS_EXT_INTR])
    else $error("system mask set visible without serialization");
  a_bank_wait: assert property (bank_stall && loads_outstanding |=> $stable(gr_bank_select))
    else $error("bank changed with loads outstanding");
  a_priv_fault: assert property (needs_priv && !intr_take && !privileged |=>
      priv_fault && $stable(status_word[POS_CPL_HI:POS_CPL_LO]))
    else $error("privileged command not refused");
  a_defer_purge: assert property (first_native && status_word[POS_DEFER] &&
      first_class == PSW_CL_SPEC_ADV |=> advanced_load_table_purge && force_defer_mark)
    else $error("advanced load not purged");

endmodule

// *** tb.sv ***
// Self-checking bench for the status word bank: commands, interruptions,
// first-instruction pulses. Assumes the package and the bank are compiled first.
`timescale 1ns/10ps
module tb;
  import psw_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic        clk = 0, reset_n = 0, op_valid = 0, intr_take = 0, first_valid = 0;
  logic        loads = 0;
  psw_op_t     op_code = PSW_OP_NONE;
  logic [63:0] op_data = '0;
  psw_int_t    intr_kind = PSW_INT_NORMAL;
  logic [1:0]  nslot = '0;
  psw_class_t  fcls = PSW_CL_OTHER;
  logic [63:0] sw, vis, sav, rd;
  logic        rv, pf, bank, stall, fdm, mas, ap, ps, afs;
  logic [2:0]  sen;
  int          n_fail = 0, cmp_count = 0;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  psw_status_bank #(.SLOTS(3)) dut (.clk(clk), .reset_n(reset_n), .op_valid(op_valid),
    .op_code(op_code), .op_data(op_data), .intr_take(intr_take), .intr_kind(intr_kind),
    .intr_next_slot(nslot), .first_valid(first_valid), .first_class(fcls),
    .loads_outstanding(loads), .status_word(sw), .status_visible(vis),
    .saved_status_copy(sav), .read_data(rd), .read_valid(rv), .priv_fault(pf),
    .gr_bank_select(bank), .bank_stall(stall), .slot_enable(sen), .force_defer_mark(fdm),
    .mem_access_suppress(mas), .advanced_load_table_purge(ap), .promotion_skip(ps),
    .accessbit_fault_suppress(afs));

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One command pulse after an idle edge, so back-to-back calls never
  // lower and raise op_valid in the same time step; returns after the taking edge
  task automatic cmd(input psw_op_t c, input logic [63:0] d);
    @(posedge clk);
    #1;
    op_valid = 1;
    op_code = c;
    op_data = d;
    @(posedge clk);
    #1;
    op_valid = 0;
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Reserved bits and slot code 11 ride along; the saved-copy write strips the reserved bits and the restore of slot code 11 disables every slot
  task automatic t_restore();
    cmd(PSW_OP_SAVED_WR, 64'hFFFF_FFF8_FFFF_FFFF);
    cmd(PSW_OP_RFI, 64'h0000_0000_0000_0000);
    chk("status_word", 64'h0000_3FF8_FFFF_FFFF, sw);
    chk("status_visible", 64'h0000_3FF8_FFFF_FFFF, vis);
    chk("slot_enable", 64'h0, 64'(sen));
    chk("gr_bank_select", 64'h1, 64'(bank));
    cmd(PSW_OP_MOV_FROM, 64'h0000_0000_0000_0000);
    chk("read_data", 64'h0000_0018_FFFF_FFFF, rd);
    chk("read_valid", 64'h1, 64'(rv));
  endtask
  // Deferral and access-bit disable both set; every class in turn
  task automatic t_first();
    logic [4:0] ex [4] = '{5'b00001, 5'b11001, 5'b11101, 5'b01011};
    for (int i = 0; i < 4; i++) begin
      fcls = psw_class_t'(i);
      first_valid = 1;
      @(posedge clk);
      #1;
      first_valid = 0;
      chk("first_outputs", 64'(ex[i]), 64'({fdm, mas, ap, ps, afs}));
      @(posedge clk);
      #1;
      chk("first_idle", 64'h0, 64'({fdm, mas, ap, ps, afs}));
    end
    cmd(PSW_OP_RETIRE, 64'h0000_0000_0000_0000);
    chk("one_shots", 64'h0, sw & MASK_ONESHOT);
  endtask
  task automatic t_slots();
    for (int s = 0; s < 4; s++) begin
      cmd(PSW_OP_SAVED_WR, 64'(s) << 41);
      cmd(PSW_OP_RFI, 64'h0000_0000_0000_0000);
      chk("slot_enable", 64'(3'(3'b111 << s)), 64'(sen));
    end
  endtask
  // Each interruption kind from a word with bank one and translation on
  task automatic t_intr();
    for (int k = 0; k < 4; k++) begin
      cmd(PSW_OP_SAVED_WR, 64'h0000_1010_0000_0000);
      cmd(PSW_OP_RFI, 64'h0000_0000_0000_0000);
      intr_kind = psw_int_t'(k);
      nslot = 2'(k);
      intr_take = 1;
      @(posedge clk);
      #1;
      intr_take = 0;
      chk("mc_mask", 64'(k == 1 || k == 2), 64'(sw[POS_MC_MASK]));
      chk("it_enable", 64'(k != 3), 64'(sw[POS_IT_EN]));
      chk("bank_after_intr", 64'h0, 64'(bank));
      chk("saved_copy", 64'h0000_1010_0000_0000 | (64'(k) << 41), sav);
    end
  endtask
  // Switch must wait while old-bank loads are still in flight
  task automatic t_bank();
    loads = 1;
    cmd(PSW_OP_BSW, 64'h0000_0000_0000_0001);
    chk("stall_high", 64'h1, 64'(stall));
    chk("bank_held", 64'h0, 64'(bank));
    @(posedge clk);
    #1;
    loads = 0;
    @(posedge clk);
    #1;
    chk("bank_new", 64'h1, 64'(bank));
    chk("stall_low", 64'h0, 64'(stall));
  endtask
  // Mask set waits for serialization, clear acts at once; then least privilege
  task automatic t_mask();
    cmd(PSW_OP_SSM, 64'h0000_0000_0000_4000);
    chk("ssm_word", 64'h4000, sw & 64'h0000_0000_0000_4000);
    chk("ssm_visible", 64'h0, vis & 64'h0000_0000_0000_4000);
    cmd(PSW_OP_SRLZ, 64'h0000_0000_0000_0000);
    chk("srlz_visible", 64'h4000, vis & 64'h0000_0000_0000_4000);
    cmd(PSW_OP_RSM, 64'h0000_0000_0000_4000);
    chk("rsm_visible", 64'h0, vis & 64'h0000_0000_0000_4000);
    cmd(PSW_OP_SAVED_WR, 64'h0000_0003_0000_0000);
    cmd(PSW_OP_RFI, 64'h0000_0000_0000_0000);
    cmd(PSW_OP_SSM, 64'h0000_0000_0000_4000);
    chk("priv_fault", 64'h1, 64'(pf));
    chk("ssm_refused", 64'h0, sw & 64'h0000_0000_0000_4000);
    cmd(PSW_OP_SUM, 64'h0000_0000_0000_0001);
    chk("user_mask", 64'h1, sw & MASK_USER);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1;
    chk("reset_word", 64'h0, sw);
    chk("reset_slots", 64'h7, 64'(sen));
    t_restore();
    t_first();
    t_slots();
    t_intr();
    t_bank();
    t_mask();
    wrap_up();
  end
  // Whole run is well under 200 cycles; 4000 leaves ample margin
  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end
endmodule
